//--- pkg/hall_seq_regs.svh
// Constants of the measurement sequencer: timing counts, widths, reset values
`ifndef HALL_SEQ_REGS_SVH
`define HALL_SEQ_REGS_SVH

`define CLK_HZ           20000000
`define BIAS_SETTLE_NS   2000
`define BIAS_SETTLE_CYC  ((`BIAS_SETTLE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define OSC_START_NS     1000
`define OSC_START_CYC    ((`OSC_START_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define FIELD_BITS       12
`define TEMP_BITS        10
`define TEMP_EN_RST      1'b1
`define MODE_RST         2'h0
`define RATE_RST         3'h0
`define INT_PULSE_CYC    4

`endif

//--- pkg/hall_seq_pkg.sv
// Types shared by the measurement sequencer
package hall_seq_pkg;

  typedef enum logic [3:0] {
    ST_HALT    = 4'h0,
    ST_LOWPWR  = 4'h1,
    ST_WAKE    = 4'h3,
    ST_BIAS    = 4'h2,
    ST_CONV_X  = 4'h6,
    ST_CONV_Y  = 4'h7,
    ST_CONV_Z  = 4'h5,
    ST_CONV_T  = 4'h4,
    ST_PUBLISH = 4'hc,
    ST_IRQ     = 4'hd
  } seq_state_e;

  typedef enum logic [1:0] {
    CH_X = 2'h0,
    CH_Y = 2'h1,
    CH_Z = 2'h2,
    CH_T = 2'h3
  } adc_chan_e;

endpackage

//--- design/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/100ps
module pin_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_pin,
  output logic      o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  always_comb begin
    state_next     = state_reg;
    state_next.s1  = i_pin;
    state_next.s2  = state_reg.s1;
    state_next.s3  = state_reg.s2;
    // Only an agreed value counts, so one metastable sample cannot toggle
    if (state_reg.s2 == state_reg.s3) begin
      state_next.lvl = state_reg.s3;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.lvl;
endmodule

//--- design/hall_measurement_sequencer.sv
// Measurement sequencer of a three-axis Hall sensor: power, conversion order, interrupt
// Summary of operation
// - Start-up settles in low power, then configurable
// - Config change starts cycle: bias and oscillator together, then wake count
// - Hall bias, three channels, return to mode
// - Order X, Y, Z, then optional temperature
// - Low supply halts machine; restart from beginning
// - Supply restart mid-sequence abandons; waits in low power for next config
// - Completion on active-low open-drain pin shared with clock
// - Device is bus slave; master starts transfers
// - Field results 12 bits, temperature 10 bits
// - Mode and rate changeable while running
// - Low-power clock for mode; fast oscillator only measuring
`timescale 1ns/100ps
`include "hall_seq_regs.svh"
module hall_measurement_sequencer #(
  parameter int FIELD_W    = `FIELD_BITS,
  parameter int TEMP_W     = `TEMP_BITS,
  parameter int BIAS_CYC   = `BIAS_SETTLE_CYC,
  parameter int OSC_CYC    = `OSC_START_CYC,
  parameter int IRQ_CYC    = `INT_PULSE_CYC
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_supply_ok,
  input  wire logic               i_scl,
  input  wire logic               i_cfg_wr,
  input  wire logic [1:0]         i_cfg_mode,
  input  wire logic [2:0]         i_cfg_rate,
  input  wire logic               i_cfg_temp_en,
  input  wire logic               i_adc_done,
  input  wire logic [FIELD_W-1:0] i_adc_data,
  output logic                    o_scl_int_out,
  output logic                    o_scl_int_oe_n,
  output logic                    o_bias_en,
  output logic                    o_hall_bias_en,
  output logic                    o_fast_osc_en,
  output logic                    o_adc_start,
  output logic [1:0]              o_adc_chan,
  output logic [1:0]              o_power_mode,
  output logic [2:0]              o_update_rate,
  output logic                    o_busy,
  output logic [FIELD_W-1:0]      o_bx,
  output logic [FIELD_W-1:0]      o_by,
  output logic [FIELD_W-1:0]      o_bz,
  output logic [TEMP_W-1:0]       o_temp
);

  // Counters are eight bits wide and the temperature slice assumes these widths
  if (FIELD_W != 12 || TEMP_W != 10 || TEMP_W > FIELD_W) begin : g_bad_width
    $error("Result widths unsupported");
  end
  if (BIAS_CYC < 1 || BIAS_CYC > 255 || OSC_CYC < 1 || OSC_CYC > 255) begin : g_bad_settle
    $error("Settle counts out of range");
  end
  if (IRQ_CYC < 1 || IRQ_CYC > 255) begin : g_bad_irq
    $error("Interrupt pulse length out of range");
  end

  typedef struct packed {
    hall_seq_pkg::seq_state_e st;
    logic [7:0]               cnt;
    logic                     pending;
    logic                     conv_busy;
    logic                     bias_en;
    logic                     hall_bias_en;
    logic                     fast_osc_en;
    logic                     adc_start;
    logic [1:0]               adc_chan;
    logic [1:0]               mode;
    logic [2:0]               rate;
    logic                     temp_en;
    logic                     int_drive;
    logic [FIELD_W-1:0]       sx;
    logic [FIELD_W-1:0]       sy;
    logic [FIELD_W-1:0]       sz;
    logic [TEMP_W-1:0]        st_t;
    logic [FIELD_W-1:0]       bx;
    logic [FIELD_W-1:0]       by;
    logic [FIELD_W-1:0]       bz;
    logic [TEMP_W-1:0]        temp;
  } seq_s;

  seq_s state_reg;
  seq_s state_next;
  logic supply_lvl;
  logic scl_lvl;

  // Supply supervision arrives asynchronously from the analog restart circuit
  pin_sync3 #(
    .RST_VAL (1'b0)
  ) u_supply_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_supply_ok),
    .o_level   (supply_lvl)
  );

  // Shared pin is sampled so the interrupt only starts while the clock is seen high
  pin_sync3 #(
    .RST_VAL (1'b1)
  ) u_scl_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_pin     (i_scl),
    .o_level   (scl_lvl)
  );

  always_comb begin
    state_next           = state_reg;
    state_next.adc_start = 1'b0;
    // Configuration is accepted at any time without reset
    if (i_cfg_wr) begin
      state_next.mode    = i_cfg_mode;
      state_next.rate    = i_cfg_rate;
      state_next.temp_en = i_cfg_temp_en;
      state_next.pending = 1'b1;
    end
    if (!supply_lvl) begin
      // Abandon any cycle; measuring resources are released at once
      state_next.st           = hall_seq_pkg::ST_HALT;
      state_next.bias_en      = 1'b0;
      state_next.hall_bias_en = 1'b0;
      state_next.fast_osc_en  = 1'b0;
      state_next.conv_busy    = 1'b0;
      state_next.int_drive    = 1'b0;
    end else begin
      case (state_reg.st)
        hall_seq_pkg::ST_HALT: begin
          // Restart from the beginning once supply is adequate
          state_next.st = hall_seq_pkg::ST_LOWPWR;
        end
        hall_seq_pkg::ST_LOWPWR: begin
          if (state_reg.pending || i_cfg_wr) begin
            state_next.pending     = 1'b0;
            state_next.bias_en     = 1'b1;
            state_next.fast_osc_en = 1'b1;
            state_next.cnt         = 8'(OSC_CYC);
            state_next.st          = hall_seq_pkg::ST_WAKE;
          end
        end
        hall_seq_pkg::ST_WAKE: begin
          // Oscillator start-up count, then Hall bias with its settle count
          if (state_reg.cnt > 8'h01) begin
            state_next.cnt = state_reg.cnt - 8'h01;
          end else begin
            state_next.hall_bias_en = 1'b1;
            state_next.cnt          = 8'(BIAS_CYC);
            state_next.st           = hall_seq_pkg::ST_BIAS;
          end
        end
        hall_seq_pkg::ST_BIAS: begin
          if (state_reg.cnt > 8'h01) begin
            state_next.cnt = state_reg.cnt - 8'h01;
          end else begin
            state_next.adc_chan  = hall_seq_pkg::CH_X;
            state_next.adc_start = 1'b1;
            state_next.conv_busy = 1'b1;
            state_next.st        = hall_seq_pkg::ST_CONV_X;
          end
        end
        hall_seq_pkg::ST_CONV_X: begin
          if (state_reg.conv_busy && i_adc_done) begin
            state_next.sx        = i_adc_data;
            state_next.adc_chan  = hall_seq_pkg::CH_Y;
            state_next.adc_start = 1'b1;
            state_next.st        = hall_seq_pkg::ST_CONV_Y;
          end
        end
        hall_seq_pkg::ST_CONV_Y: begin
          if (i_adc_done) begin
            state_next.sy        = i_adc_data;
            state_next.adc_chan  = hall_seq_pkg::CH_Z;
            state_next.adc_start = 1'b1;
            state_next.st        = hall_seq_pkg::ST_CONV_Z;
          end
        end
        hall_seq_pkg::ST_CONV_Z: begin
          if (i_adc_done) begin
            state_next.sz = i_adc_data;
            if (state_reg.temp_en) begin
              state_next.adc_chan  = hall_seq_pkg::CH_T;
              state_next.adc_start = 1'b1;
              state_next.st        = hall_seq_pkg::ST_CONV_T;
            end else begin
              state_next.st = hall_seq_pkg::ST_PUBLISH;
            end
          end
        end
        hall_seq_pkg::ST_CONV_T: begin
          if (i_adc_done) begin
            // Temperature keeps the upper bits of the converter word
            state_next.st_t = i_adc_data[FIELD_W-1 -: TEMP_W];
            state_next.st   = hall_seq_pkg::ST_PUBLISH;
          end
        end
        hall_seq_pkg::ST_PUBLISH: begin
          // Whole set lands in one edge, before the interrupt
          state_next.bx           = state_reg.sx;
          state_next.by           = state_reg.sy;
          state_next.bz           = state_reg.sz;
          state_next.temp         = state_reg.temp_en ? state_reg.st_t : state_reg.temp;
          state_next.conv_busy    = 1'b0;
          state_next.hall_bias_en = 1'b0;
          state_next.fast_osc_en  = 1'b0;
          state_next.bias_en      = 1'b0;
          state_next.cnt          = 8'(IRQ_CYC);
          state_next.st           = hall_seq_pkg::ST_IRQ;
        end
        hall_seq_pkg::ST_IRQ: begin
          if (state_reg.cnt != 8'h00) begin
            // Start only on a high clock; once pulling, our own low is not the master's
            state_next.int_drive = state_reg.int_drive | scl_lvl;
            state_next.cnt       = state_reg.cnt - 8'h01;
          end else begin
            state_next.int_drive = 1'b0;
            state_next.st        = hall_seq_pkg::ST_LOWPWR;
          end
        end
        default: begin
          state_next.st = hall_seq_pkg::ST_HALT;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_reg              <= '0;
      state_reg.st           <= hall_seq_pkg::ST_HALT;
      state_reg.mode         <= `MODE_RST;
      state_reg.rate         <= `RATE_RST;
      state_reg.temp_en      <= `TEMP_EN_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Open-drain: output low always, enable active low while pulling
  assign o_scl_int_out  = 1'b0;
  assign o_scl_int_oe_n = ~state_reg.int_drive;
  assign o_bias_en      = state_reg.bias_en;
  assign o_hall_bias_en = state_reg.hall_bias_en;
  assign o_fast_osc_en  = state_reg.fast_osc_en;
  assign o_adc_start    = state_reg.adc_start;
  assign o_adc_chan     = state_reg.adc_chan;
  assign o_power_mode   = state_reg.mode;
  assign o_update_rate  = state_reg.rate;
  assign o_busy         = state_reg.conv_busy;
  assign o_bx           = state_reg.bx;
  assign o_by           = state_reg.by;
  assign o_bz           = state_reg.bz;
  assign o_temp         = state_reg.temp;
endmodule

//--- dv/hall_seq_asserts.sv
// Port checker of the measurement sequencer
`timescale 1ns/100ps
module hall_seq_asserts #(
  parameter int FIELD_W = 12
) (
  input wire logic               i_sys_clk,
  input wire logic               i_rstn,
  input wire logic               i_supply_ok,
  input wire logic               i_cfg_wr,
  input wire logic [1:0]         i_cfg_mode,
  input wire logic [2:0]         i_cfg_rate,
  input wire logic               i_adc_done,
  input wire logic               o_scl_int_out,
  input wire logic               o_scl_int_oe_n,
  input wire logic               o_bias_en,
  input wire logic               o_hall_bias_en,
  input wire logic               o_fast_osc_en,
  input wire logic               o_adc_start,
  input wire logic [1:0]         o_adc_chan,
  input wire logic [1:0]         o_power_mode,
  input wire logic [2:0]         o_update_rate,
  input wire logic               o_busy,
  input wire logic [FIELD_W-1:0] o_bx
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence wake_s;
    o_fast_osc_en && o_bias_en && !o_hall_bias_en;
  endsequence
  sequence meas_s;
    o_hall_bias_en && o_bias_en && o_fast_osc_en;
  endsequence
  a_int_pull_low: assert property (o_scl_int_out == 1'b0)
    else $error("interrupt pin data not low");
  a_wake_then_bias: assert property ($rose(o_fast_osc_en) |-> wake_s [*2] ##[1:40] meas_s)
    else $error("hall bias not after wake");
  a_adc_when_meas: assert property (o_adc_start |-> meas_s and o_busy)
    else $error("conversion outside measurement");
  a_first_is_x: assert property ($rose(o_busy) |-> o_adc_start && o_adc_chan == 2'h0)
    else $error("first channel not X");
  a_next_on_done: assert property (o_adc_start && o_adc_chan != 2'h0 |-> $past(i_adc_done))
    else $error("channel advanced without result");
  a_halt_low: assert property (!i_supply_ok [*8] |-> !o_fast_osc_en && !o_busy && o_scl_int_oe_n)
    else $error("not halted on low supply");
  a_cfg_apply: assert property (i_cfg_wr |=> o_power_mode == $past(i_cfg_mode)
    && o_update_rate == $past(i_cfg_rate))
    else $error("config not applied");
  a_irq_after: assert property ($fell(o_scl_int_oe_n) |-> !o_busy && !o_fast_osc_en && $stable(o_bx))
    else $error("interrupt before results settled");
  a_irq_short: assert property (!o_scl_int_oe_n [*6] |=> o_scl_int_oe_n)
    else $error("interrupt held too long");
endmodule

bind hall_measurement_sequencer hall_seq_asserts #(.FIELD_W(FIELD_W)) i_hall_seq_asserts (
  .i_sys_clk, .i_rstn, .i_supply_ok, .i_cfg_wr, .i_cfg_mode, .i_cfg_rate, .i_adc_done,
  .o_scl_int_out, .o_scl_int_oe_n, .o_bias_en, .o_hall_bias_en, .o_fast_osc_en,
  .o_adc_start, .o_adc_chan, .o_power_mode, .o_update_rate, .o_busy, .o_bx);

//--- dv/adc_model.sv
// Converter stand-in: answers each start after a chosen delay
`timescale 1ns/100ps
module adc_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_start,
  input  wire logic [1:0]  i_chan,
  input  wire logic [11:0] i_base,
  input  wire logic [3:0]  i_delay,
  output logic             o_done,
  output logic [11:0]      o_data
);
  logic [3:0]  cnt  = 4'h0;
  logic        run  = 1'b0;
  logic [11:0] word = 12'h000;
  initial o_done = 1'b0;
  always @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    if (i_start) begin
      run  <= 1'b1;
      cnt  <= i_delay;
      word <= i_base + {10'h000, i_chan};
    end else if (run && cnt == 4'h0) begin
      run    <= 1'b0;
      o_done <= 1'b1;
    end else if (run) begin
      cnt <= cnt - 4'h1;
    end
  end
  // Stale word inverted so a late capture cannot match
  assign o_data = o_done ? word : ~word;
endmodule

//--- dv/hall_measurement_sequencer_tb.sv
// Self-checking bench of the measurement sequencer
`timescale 1ns/100ps
module hall_measurement_sequencer_tb;
  logic        sys_clk = 1'b0, rstn = 1'b0, supply_ok = 1'b0, cfg_wr = 1'b0;
  logic        scl_hold = 1'b0, scl_run = 1'b0, sclk = 1'b1, te = 1'b1, oe_q = 1'b1;
  logic        bq = 1'b0, oe_n, osc, start, busy, adc_done, scl;
  logic [1:0]  mode = 2'h0, chan, pmode;
  logic [2:0]  rate = 3'h0, urate;
  logic [3:0]  dly = 4'h0;
  logic [9:0]  temp;
  logic [11:0] base = 12'h000, adc_data, bx, by, bz;
  logic [31:0] rng = 32'h34ce;
  logic [17:0] q[$];
  int          n_fail = 0, n_tests = 0, cyc = 0, starts = 0;
  always #25 sys_clk = ~sys_clk;
  // Link clock only runs inside a transfer
  always #200 sclk = scl_run ? ~sclk : 1'b1;
  // Shared pin pulled high unless someone pulls it low
  assign scl = (!oe_n || scl_hold) ? 1'b0 : sclk;
  hall_measurement_sequencer #(.BIAS_CYC(4), .OSC_CYC(4), .IRQ_CYC(2))
  i_hall_measurement_sequencer (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_supply_ok(supply_ok), .i_scl(scl),
    .i_cfg_wr(cfg_wr), .i_cfg_mode(mode), .i_cfg_rate(rate), .i_cfg_temp_en(te),
    .i_adc_done(adc_done), .i_adc_data(adc_data), .o_scl_int_out(),
    .o_scl_int_oe_n(oe_n), .o_bias_en(), .o_hall_bias_en(), .o_fast_osc_en(osc),
    .o_adc_start(start), .o_adc_chan(chan), .o_power_mode(pmode), .o_update_rate(urate),
    .o_busy(busy), .o_bx(bx), .o_by(by), .o_bz(bz), .o_temp(temp));
  adc_model i_adc_model (.i_sys_clk(sys_clk), .i_start(start), .i_chan(chan),
    .i_base(base), .i_delay(dly), .o_done(adc_done), .o_data(adc_data));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Master write of a new configuration; note holds the expected cycle
  task automatic cfg(input logic [1:0] m, input logic [2:0] r, input logic t,
                     input logic push, input logic nb);
    @(negedge sys_clk);
    rng = xs(rng);
    if (nb) base = rng[11:0];
    dly = rng[15:12];
    mode = m;
    rate = r;
    te = t;
    cfg_wr = 1'b1;
    if (push) q.push_back({m, r, t, base});
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic settle();
    repeat (16) @(negedge sys_clk);
    while (q.size() != 0 || busy !== 1'b0 || oe_n !== 1'b1) @(negedge sys_clk);
    repeat (12) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // Interrupt taken as the moment to read results
  always @(negedge sys_clk) begin
    logic [17:0] n;
    if (busy && !bq) starts = 0;
    if (start) starts++;
    if (oe_q && !oe_n) begin
      if (q.size() == 0) chk(12'h1, 12'h0);
      else begin
        n = q.pop_front();
        chk(12'(pmode), 12'(n[17:16]));
        chk(12'(urate), 12'(n[15:13]));
        chk(12'(starts), n[12] ? 12'h4 : 12'h3);
        chk(bx, n[11:0]);
        chk(by, n[11:0] + 12'h1);
        chk(bz, n[11:0] + 12'h2);
        if (n[12]) chk(12'(temp), 12'((n[11:0] + 12'h3) >> 2));
      end
    end
    oe_q <= oe_n;
    bq <= busy;
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    chk(12'(pmode), 12'h0);
    cfg(2'h1, 3'h2, 1'b1, 1'b1, 1'b1);
    repeat (20) @(negedge sys_clk);
    chk(12'(osc), 12'h0);
    supply_ok = 1'b1;
    settle();
    $display("test supply start done");
    for (int i = 0; i < 8; i++) begin
      cfg(2'(i), 3'(i), i[0], 1'b1, 1'b1);
      settle();
    end
    $display("test mode sweep done");
    cfg(2'h2, 3'h5, 1'b0, 1'b1, 1'b1);
    repeat (3) @(negedge sys_clk);
    cfg(2'h2, 3'h5, 1'b0, 1'b1, 1'b0);
    settle();
    $display("test pending rerun done");
    cfg(2'h3, 3'h1, 1'b1, 1'b0, 1'b1);
    while (busy !== 1'b1) @(negedge sys_clk);
    supply_ok = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(12'(busy), 12'h0);
    supply_ok = 1'b1;
    settle();
    $display("test supply drop done");
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    chk(12'(pmode), 12'h0);
    chk(12'(busy), 12'h0);
    $display("test second reset done");
    scl_hold = 1'b1;
    cfg(2'h0, 3'h3, 1'b1, 1'b0, 1'b1);
    settle();
    chk(bx, base);
    scl_hold = 1'b0;
    scl_run = 1'b1;
    repeat (40) @(negedge sys_clk);
    scl_run = 1'b0;
    $display("test line held done");
    summarize();
  end
endmodule
